/* File: common/gio_pkg.sv */
// Package with the constants, types and decode helpers of the general purpose ports.
// Functional notes
// - Seven 8-bit ports, data at 0x12..0x25.
// - Input read unlatched, pad sampled at phase two.
// - Output latch holds until rewritten.
// - Per-line direction bit, 1 input, 0 output.
// - Read returns pad if input, latch otherwise.
// - Direction registers follow data, last at 0x26.
// - Output lines always drive push-pull.
// - Lines undriven after reset, pulled per option.
// - Bit operations read, modify, write back latch.
// - Any port A line wakes halted device.
// - Build-time pull-high option per line.
// - Serial enables take over TX/RX, drop RX pull.
package gio_pkg;

  localparam int NUM_PORTS = 7;
  localparam int PORT_W    = 8;
  localparam int ADDR_W    = 8;

  // Index 0 is port A, index 6 is port G.
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] DATA_ADDR = {
    8'h25, 8'h1c, 8'h1a, 8'h18, 8'h16, 8'h14, 8'h12
  };
  localparam logic [NUM_PORTS-1:0][ADDR_W-1:0] DIR_ADDR = {
    8'h26, 8'h1d, 8'h1b, 8'h19, 8'h17, 8'h15, 8'h13
  };

  localparam logic [PORT_W-1:0] DATA_RST = 8'h00;
  localparam logic [PORT_W-1:0] DIR_RST  = 8'hff;

  // Shared serial lines sit on port C.
  localparam int PORT_A      = 0;
  localparam int SER_PORT    = 2;
  localparam int SER_TX_BIT  = 0;
  localparam int SER_RX_BIT  = 1;

  typedef logic [NUM_PORTS-1:0][PORT_W-1:0] gio_lines_t;

  typedef struct packed {
    gio_lines_t out;
    gio_lines_t oe;
    gio_lines_t pull;
  } gio_pad_drv_s;

  typedef struct packed {
    logic       hit;
    logic       dir;
    logic [2:0] idx;
  } gio_dec_s;

  function automatic gio_dec_s gio_decode(input logic [ADDR_W-1:0] a);
    gio_dec_s d;
    d = '0;
    for (int i = 0; i < NUM_PORTS; i++) begin
      if (a == DATA_ADDR[i]) begin
        d.hit = 1'b1;
        d.dir = 1'b0;
        d.idx = 3'(i);
      end
      if (a == DIR_ADDR[i]) begin
        d.hit = 1'b1;
        d.dir = 1'b1;
        d.idx = 3'(i);
      end
    end
    return d;
  endfunction

  function automatic logic [PORT_W-1:0] gio_port_view(input logic [PORT_W-1:0] dir,
                                                      input logic [PORT_W-1:0] latch,
                                                      input logic [PORT_W-1:0] pad);
    return (dir & pad) | (~dir & latch);
  endfunction

endpackage

/* File: hw/gio_ports.sv */
// Seven bidirectional general purpose ports on the data memory bus.
module gio_ports #(
  parameter gio_pkg::gio_lines_t PULL_HIGH_OPT = '0
) (
  input  wire logic                        clk,
  input  wire logic                        rst,
  input  wire logic [gio_pkg::ADDR_W-1:0]  mem_addr,
  input  wire logic [gio_pkg::PORT_W-1:0]  mem_wdata,
  input  wire logic                        mem_wr,
  input  wire logic                        mem_rd,
  input  wire logic                        instruction_phase_two,
  output logic      [gio_pkg::PORT_W-1:0]  mem_rdata,
  output logic                             mem_rhit,
  input  wire gio_pkg::gio_lines_t         pad_in,
  output gio_pkg::gio_pad_drv_s            pad_drv,
  input  wire logic                        halted,
  output logic                             wake_req,
  input  wire logic                        serial_unit_enable,
  input  wire logic                        serial_transmit_enable,
  input  wire logic                        serial_receive_enable,
  input  wire logic                        serial_tx_data,
  output logic                             serial_rx_data
);

  gio_pkg::gio_lines_t           latch_all;
  gio_pkg::gio_lines_t           dir_all;
  gio_pkg::gio_lines_t           port_view;
  gio_pkg::gio_lines_t           nxt_out;
  gio_pkg::gio_lines_t           nxt_oe;
  gio_pkg::gio_lines_t           nxt_pull;
  gio_pkg::gio_lines_t           pad_out_ff;
  gio_pkg::gio_lines_t           pad_oe_ff;
  gio_pkg::gio_lines_t           pad_pull_ff;
  gio_pkg::gio_dec_s             wdec;
  gio_pkg::gio_dec_s             rdec;
  logic [gio_pkg::PORT_W-1:0]    port_a_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_b_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_c_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_d_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_e_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_f_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_g_data_ff;
  logic [gio_pkg::PORT_W-1:0]    port_a_dir_ff;
  logic [gio_pkg::PORT_W-1:0]    port_b_dir_ff;
  logic [gio_pkg::PORT_W-1:0]    port_c_dir_ff;
  logic [gio_pkg::PORT_W-1:0]    port_d_dir_ff;
  logic [gio_pkg::PORT_W-1:0]    port_e_dir_ff;
  logic [gio_pkg::PORT_W-1:0]    port_f_dir_ff;
  logic [gio_pkg::PORT_W-1:0]    port_g_dir_ff;
  logic [gio_pkg::NUM_PORTS-1:0] data_we;
  logic [gio_pkg::NUM_PORTS-1:0] dir_we;
  logic [gio_pkg::PORT_W-1:0]    rdata_ff;
  logic [gio_pkg::PORT_W-1:0]    nxt_rdata;
  logic [gio_pkg::PORT_W-1:0]    prev_a_ff;
  logic                          rhit_ff;
  logic                          rd_take;
  logic                          wake_ff;
  logic                          rx_ff;
  logic                          tx_take;
  logic                          rx_take;

  // One strobe per port, so a write touches only the register it addresses.
  function automatic logic [gio_pkg::NUM_PORTS-1:0] bank_we(input gio_pkg::gio_dec_s d,
                                                            input logic              wr,
                                                            input logic              dir_bank);
    logic [gio_pkg::NUM_PORTS-1:0] we;
    we = '0;
    if (wr && d.hit && (d.dir == dir_bank)) begin
      we[d.idx] = 1'b1;
    end
    return we;
  endfunction

  assign wdec    = gio_pkg::gio_decode(mem_addr);
  assign rdec    = gio_pkg::gio_decode(mem_addr);
  assign rd_take = mem_rd & instruction_phase_two;
  assign tx_take = serial_unit_enable & serial_transmit_enable;
  assign rx_take = serial_unit_enable & serial_receive_enable;
  assign data_we = bank_we(wdec, mem_wr, 1'b0);
  assign dir_we  = bank_we(wdec, mem_wr, 1'b1);

  // Each register keeps its value until a write strobes it or reset loads it; nothing else touches it.
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[0]) begin
      port_a_data_ff <= mem_wdata;
    end else begin
      port_a_data_ff <= port_a_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_b_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[1]) begin
      port_b_data_ff <= mem_wdata;
    end else begin
      port_b_data_ff <= port_b_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_c_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[2]) begin
      port_c_data_ff <= mem_wdata;
    end else begin
      port_c_data_ff <= port_c_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_d_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[3]) begin
      port_d_data_ff <= mem_wdata;
    end else begin
      port_d_data_ff <= port_d_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_e_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[4]) begin
      port_e_data_ff <= mem_wdata;
    end else begin
      port_e_data_ff <= port_e_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_f_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[5]) begin
      port_f_data_ff <= mem_wdata;
    end else begin
      port_f_data_ff <= port_f_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_g_data_ff <= gio_pkg::DATA_RST;
    end else if (data_we[6]) begin
      port_g_data_ff <= mem_wdata;
    end else begin
      port_g_data_ff <= port_g_data_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[0]) begin
      port_a_dir_ff <= mem_wdata;
    end else begin
      port_a_dir_ff <= port_a_dir_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_b_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[1]) begin
      port_b_dir_ff <= mem_wdata;
    end else begin
      port_b_dir_ff <= port_b_dir_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_c_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[2]) begin
      port_c_dir_ff <= mem_wdata;
    end else begin
      port_c_dir_ff <= port_c_dir_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_d_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[3]) begin
      port_d_dir_ff <= mem_wdata;
    end else begin
      port_d_dir_ff <= port_d_dir_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_e_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[4]) begin
      port_e_dir_ff <= mem_wdata;
    end else begin
      port_e_dir_ff <= port_e_dir_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_f_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[5]) begin
      port_f_dir_ff <= mem_wdata;
    end else begin
      port_f_dir_ff <= port_f_dir_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      port_g_dir_ff <= gio_pkg::DIR_RST;
    end else if (dir_we[6]) begin
      port_g_dir_ff <= mem_wdata;
    end else begin
      port_g_dir_ff <= port_g_dir_ff;
    end
  end

  // Port A sits at index 0, the same order the address decode hands out.
  assign latch_all = {port_g_data_ff,
                      port_f_data_ff,
                      port_e_data_ff,
                      port_d_data_ff,
                      port_c_data_ff,
                      port_b_data_ff,
                      port_a_data_ff};
  assign dir_all   = {port_g_dir_ff,
                      port_f_dir_ff,
                      port_e_dir_ff,
                      port_d_dir_ff,
                      port_c_dir_ff,
                      port_b_dir_ff,
                      port_a_dir_ff};

  // Output lines return the latch so set, clear and complement keep other bits intact.
  always_comb begin
    for (int i = 0; i < gio_pkg::NUM_PORTS; i++) begin
      port_view[i] = gio_pkg::gio_port_view(dir_all[i], latch_all[i], pad_in[i]);
    end
  end

  always_comb begin
    nxt_rdata = '0;
    if (rdec.hit && rdec.dir) begin
      nxt_rdata = dir_all[rdec.idx];
    end else if (rdec.hit) begin
      nxt_rdata = port_view[rdec.idx];
    end
  end

  // The pad is taken only in the phase-two cycle of the read, nothing is held before it.
  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_ff <= '0;
    end else if (rd_take) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rhit_ff <= 1'b0;
    end else begin
      rhit_ff <= rd_take && rdec.hit;
    end
  end

  // The serial unit overrides the shared lines without touching latch or direction.
  always_comb begin
    nxt_out = latch_all;
    if (tx_take) begin
      nxt_out[gio_pkg::SER_PORT][gio_pkg::SER_TX_BIT] = serial_tx_data;
    end
  end

  always_comb begin
    nxt_oe = ~dir_all;
    if (tx_take) begin
      nxt_oe[gio_pkg::SER_PORT][gio_pkg::SER_TX_BIT] = 1'b1;
    end
    if (rx_take) begin
      nxt_oe[gio_pkg::SER_PORT][gio_pkg::SER_RX_BIT] = 1'b0;
    end
  end

  always_comb begin
    nxt_pull = PULL_HIGH_OPT;
    if (rx_take) begin
      nxt_pull[gio_pkg::SER_PORT][gio_pkg::SER_RX_BIT] = 1'b0;
    end
  end

  // Pad drive is registered, so a direction or latch change shows one cycle later.
  always_ff @(posedge clk) begin
    if (rst) begin
      pad_out_ff <= '0;
    end else begin
      pad_out_ff <= nxt_out;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_oe_ff <= '0;
    end else begin
      pad_oe_ff <= nxt_oe;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pad_pull_ff <= PULL_HIGH_OPT;
    end else begin
      pad_pull_ff <= nxt_pull;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rx_ff <= 1'b1;
    end else begin
      rx_ff <= pad_in[gio_pkg::SER_PORT][gio_pkg::SER_RX_BIT] | ~rx_take;
    end
  end

  // Following the pad through reset as well keeps a false edge away from the release.
  always_ff @(posedge clk) begin
    prev_a_ff <= pad_in[gio_pkg::PORT_A];
  end

  // A falling edge on any port A line while halted requests wake-up.
  always_ff @(posedge clk) begin
    if (rst) begin
      wake_ff <= 1'b0;
    end else begin
      wake_ff <= halted && |(prev_a_ff & ~pad_in[gio_pkg::PORT_A]);
    end
  end

  assign mem_rdata      = rdata_ff;
  assign mem_rhit       = rhit_ff;
  assign pad_drv        = {pad_out_ff, pad_oe_ff, pad_pull_ff};
  assign wake_req       = wake_ff;
  assign serial_rx_data = rx_ff;

endmodule

/* File: sim/gio_pins.sv */
// Pins and outside circuitry around the port block.
module gio_pins (
  input  wire logic                  clk,
  input  wire gio_pkg::gio_pad_drv_s pad_drv,
  input  wire gio_pkg::gio_lines_t   ext,
  input  wire gio_pkg::gio_lines_t   ext_en,
  output gio_pkg::gio_lines_t        pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic flt = 1'b0;
  // A floating line without its pull-high option keeps changing so that no settled level passes for a driven one.
  always @(posedge clk) flt <= ~flt;
  assign pad_in = (pad_drv.oe & pad_drv.out) | (~pad_drv.oe & ((ext_en & ext) |
    (~ext_en & (pad_drv.pull | {56{flt}}))));
endmodule

/* File: sim/gio_ports_monitor.sv */
// Checker of the port block's bus answers, pad drive and wake-up.
module gio_ports_monitor #(
  parameter gio_pkg::gio_lines_t PULL_HIGH_OPT = '0
) (
  input wire logic                  clk,
  input wire logic                  rst,
  input wire logic [7:0]            mem_addr,
  input wire logic [7:0]            mem_wdata,
  input wire logic                  mem_wr,
  input wire logic                  mem_rd,
  input wire logic                  instruction_phase_two,
  input wire logic [7:0]            mem_rdata,
  input wire logic                  mem_rhit,
  input wire gio_pkg::gio_lines_t   pad_in,
  input wire gio_pkg::gio_pad_drv_s pad_drv,
  input wire logic                  halted,
  input wire logic                  wake_req,
  input wire logic                  serial_unit_enable,
  input wire logic                  serial_transmit_enable,
  input wire logic                  serial_receive_enable,
  input wire logic                  serial_tx_data
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  sequence s_rd(a);
    mem_rd && instruction_phase_two && mem_addr == a;
  endsequence
  sequence s_wr(a);
    mem_wr && mem_addr == a;
  endsequence
  rst_pads_a: assert property (disable iff (1'b0) rst |=> pad_drv.oe == '0 &&
    pad_drv.pull == PULL_HIGH_OPT) else $error("pads not released by reset");
  rd_hit_a: assert property (s_rd(8'h12) |=> mem_rhit) else $error("port read missed");
  rd_miss_a: assert property (s_rd(8'h30) |=> !mem_rhit && mem_rdata == 8'h00)
    else $error("unmapped read answered");
  rd_idle_a: assert property (!(mem_rd && instruction_phase_two) |=> !mem_rhit)
    else $error("read answered without phase two");
  dir_out_a: assert property (s_wr(8'h13) ##1 1'b1 |=> pad_drv.oe[0] == ~$past(mem_wdata, 2))
    else $error("direction write not on drivers");
  tx_take_a: assert property (serial_unit_enable && serial_transmit_enable |=> pad_drv.oe[2][0]
    && pad_drv.out[2][0] == $past(serial_tx_data)) else $error("serial output not driven");
  rx_take_a: assert property (serial_unit_enable && serial_receive_enable |=>
    !pad_drv.pull[2][1] && !pad_drv.oe[2][1]) else $error("receive line not freed");
  wake_edge_a: assert property (halted && |($past(pad_in[0]) & ~pad_in[0]) && !$past(rst)
    |=> wake_req) else $error("wake-up missed");
endmodule

bind gio_ports gio_ports_monitor #(.PULL_HIGH_OPT(PULL_HIGH_OPT)) u_mon (.*);

/* File: sim/tb.sv */
// Bench for the general purpose port block.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rst = 1, mem_wr = 0, mem_rd = 0, instruction_phase_two = 0, halted = 0;
  logic serial_unit_enable = 0, serial_transmit_enable = 0, serial_receive_enable = 0;
  logic serial_tx_data = 1, serial_rx_data, mem_rhit, wake_req;
  logic [7:0] mem_addr = 0, mem_wdata = 0, mem_rdata, v;
  gio_pkg::gio_lines_t pad_in, ext = '0, ext_en = '0;
  gio_pkg::gio_pad_drv_s pad_drv;
  int n_errors = 0, n_compared = 0, cyc = 0;
  gio_ports #(.PULL_HIGH_OPT('1)) u_gio_ports (.*);
  gio_pins u_gio_pins (.*);
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin
    n_errors++;
    print_verdict();
  end
  task automatic chk(string what, logic [7:0] exp, logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    @(negedge clk) {mem_wr, mem_addr, mem_wdata} = {1'b1, a, d};
    @(negedge clk) mem_wr = 0;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] exp);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < 7; i++) begin
      hit |= (a == gio_pkg::DATA_ADDR[i]) || (a == gio_pkg::DIR_ADDR[i]);
    end
    @(negedge clk) {mem_rd, instruction_phase_two, mem_addr} = {2'b11, a};
    @(negedge clk) {mem_rd, instruction_phase_two} = 2'b00;
    chk("read data", exp, mem_rdata);
    chk("read hit", {7'd0, hit}, {7'd0, mem_rhit});
  endtask
  task automatic t_reset;
    for (int i = 0; i < 7; i++) begin
      rd(gio_pkg::DIR_ADDR[i], 8'hff);
      rd(gio_pkg::DATA_ADDR[i], 8'hff);
      chk("enable", 8'h00, pad_drv.oe[i]);
      chk("pull", 8'hff, pad_drv.pull[i]);
    end
    rd(8'h30, 8'h00);
  endtask
  task automatic t_ports;
    ext_en = '1;
    for (int i = 0; i < 7; i++) begin
      ext[i] = 8'h3c;
      v = 8'ha5 ^ 8'(i);
      wr(gio_pkg::DATA_ADDR[i], v);
      wr(gio_pkg::DIR_ADDR[i], 8'h0f);
      rd(gio_pkg::DIR_ADDR[i], 8'h0f);
      rd(gio_pkg::DATA_ADDR[i], 8'h0c | (v & 8'hf0));
      chk("enable", 8'hf0, pad_drv.oe[i]);
      chk("out", v & 8'hf0, pad_drv.out[i] & 8'hf0);
    end
    rd(8'h12, 8'hac);
  endtask
  task automatic t_serial;
    @(negedge clk) {serial_unit_enable, serial_transmit_enable, serial_receive_enable} = 3'b111;
    serial_tx_data = 0;
    repeat (2) @(negedge clk);
    chk("tx", 8'h01, {7'd0, pad_drv.oe[2][0] & ~pad_drv.out[2][0]});
    chk("rx pull", 8'h00, {7'd0, pad_drv.pull[2][1]});
    chk("rx", 8'h00, {7'd0, serial_rx_data});
  endtask
  task automatic t_wake;
    @(negedge clk) halted = 1;
    @(negedge clk) ext[0][2] = 0;
    @(negedge clk) chk("wake", 8'h01, {7'd0, wake_req});
    @(negedge clk) chk("wake", 8'h00, {7'd0, wake_req});
  endtask
  task automatic t_rereset;
    @(negedge clk) rst = 1;
    repeat (2) @(negedge clk);
    rst = 0;
    for (int i = 0; i < 7; i++) chk("enable", 8'h00, pad_drv.oe[i]);
    rd(gio_pkg::DIR_ADDR[6], 8'hff);
  endtask
  task automatic print_verdict;
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst = 0;
    t_reset();
    t_ports();
    t_serial();
    t_wake();
    t_rereset();
    print_verdict();
  end
endmodule
